// ---- rtl/hpp_pkg.sv ----
package hpp_pkg;
  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned HPP_DW = 8;
  localparam int unsigned HPP_AW = 11;
  // ----------------------------------------------------------------------
  // bus styles and timing
  // ----------------------------------------------------------------------
  localparam logic HPP_STYLE_SINGLE = 1'b0;
  localparam logic HPP_STYLE_DUAL   = 1'b1;
  // clock period and strobe phase times in ns
  localparam int unsigned HPP_CLK_NS    = 25;
  localparam int unsigned HPP_SETUP_NS  = 50;
  localparam int unsigned HPP_STROBE_NS = 150;
  localparam int unsigned HPP_HOLD_NS   = 50;
  localparam logic [3:0] HPP_SETUP_CYC =
    4'((HPP_SETUP_NS + HPP_CLK_NS - 1) / HPP_CLK_NS);
  localparam logic [3:0] HPP_STROBE_CYC =
    4'((HPP_STROBE_NS + HPP_CLK_NS - 1) / HPP_CLK_NS);
  localparam logic [3:0] HPP_HOLD_CYC =
    4'((HPP_HOLD_NS + HPP_CLK_NS - 1) / HPP_CLK_NS);
  // reset values of the driven pins
  localparam logic [HPP_AW-1:0] HPP_ADDR_RST = 11'h000;
  localparam logic [HPP_DW-1:0] HPP_DATA_RST = 8'h00;
  // controller states, one-hot
  typedef enum logic [3:0] {
    HPP_IDLE   = 4'h1,
    HPP_SETUP  = 4'h2,
    HPP_STROBE = 4'h4,
    HPP_HOLD   = 4'h8
  } hpp_state_t;
endpackage : hpp_pkg

// ---- rtl/hpp_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module hpp_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  // pin side
  input  wire logic [W-1:0] async_i,
  // synchronised side
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------------
  // first stage is read only by the second
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta_q <= '1;
      sync_o <= '1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : hpp_sync

// ---- rtl/hpp_host.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - single-strobe style: read-not-write low writes, high reads
// - dual-strobe style: write strobe low writes; cycle ends when it rises
// - dual-strobe style: read strobe low makes the device drive data
// - single-strobe style: output enable held at ground throughout
// - every access is ended by returning chip select high
module hpp_host
  import hpp_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // user command port
  input  wire logic              style_i,
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [HPP_AW-1:0] req_addr_i,
  input  wire logic [HPP_DW-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic      [HPP_DW-1:0] rdata_o,
  output logic                   irq_pending_o,
  // device pins
  output logic      [HPP_AW-1:0] dev_addr_o,
  input  wire logic [HPP_DW-1:0] dev_data_i,
  output logic      [HPP_DW-1:0] dev_data_o,
  output logic                   dev_data_oe_n_o,
  output logic                   dev_cs_n_o,
  output logic                   dev_rnw_wr_n_o,
  output logic                   dev_oe_rd_n_o,
  input  wire logic              dev_irq_n_i
);
  hpp_state_t        state_q;
  logic        [3:0] cnt_q;
  logic              write_q;
  logic              style_q;
  logic              irq_n_s;
  logic [HPP_DW-1:0] data_s;
  logic              phase_end;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // interrupt and read data both come from outside the clock domain
  hpp_sync #(.W(HPP_DW + 1)) u_sync (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .async_i   ({dev_irq_n_i, dev_data_i}),
    .sync_o    ({irq_n_s, data_s})
  );

  // low level on the open-drain line means pending
  assign irq_pending_o = ~irq_n_s;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  function automatic logic [3:0] phase_len(input hpp_state_t s);
    case (s)
      HPP_SETUP:  phase_len = HPP_SETUP_CYC;
      HPP_STROBE: phase_len = HPP_STROBE_CYC;
      HPP_HOLD:   phase_len = HPP_HOLD_CYC;
      default:    phase_len = 4'h1;
    endcase
  endfunction : phase_len

  assign phase_end   = (cnt_q == phase_len(state_q) - 4'h1);
  assign req_ready_o = (state_q == HPP_IDLE);

  // state and phase counter
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_q <= HPP_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        HPP_IDLE: begin
          cnt_q <= 4'h0;
          if (req_i) begin
            state_q <= HPP_SETUP;
          end
        end
        HPP_SETUP, HPP_STROBE, HPP_HOLD: begin
          if (phase_end) begin
            cnt_q <= 4'h0;
            case (state_q)
              HPP_SETUP:  state_q <= HPP_STROBE;
              HPP_STROBE: state_q <= HPP_HOLD;
              default:    state_q <= HPP_IDLE;
            endcase
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: begin
          state_q <= HPP_IDLE;
          cnt_q   <= 4'h0;
        end
      endcase
    end
  end

  // capture of the request; style is sampled once per access
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      write_q    <= 1'b0;
      style_q    <= HPP_STYLE_SINGLE;
      dev_addr_o <= HPP_ADDR_RST;
      dev_data_o <= HPP_DATA_RST;
    end else if (req_ready_o && req_i) begin
      write_q    <= req_write_i;
      style_q    <= style_i;
      dev_addr_o <= req_addr_i;
      dev_data_o <= req_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  // chip select frames the setup and strobe phases and ends the access on release
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      dev_cs_n_o      <= 1'b1;
      dev_rnw_wr_n_o  <= 1'b1;
      dev_oe_rd_n_o   <= 1'b1;
      dev_data_oe_n_o <= 1'b1;
    end else begin
      case (state_q)
        HPP_IDLE: begin
          dev_cs_n_o      <= ~req_i;
          dev_data_oe_n_o <= ~(req_i && req_write_i);
          // single style keeps output enable grounded, idle or not
          if (style_i == HPP_STYLE_SINGLE) begin
            dev_rnw_wr_n_o <= ~(req_i && req_write_i);
            dev_oe_rd_n_o  <= 1'b0;
          end else begin
            dev_rnw_wr_n_o <= 1'b1;
            dev_oe_rd_n_o  <= 1'b1;
          end
        end
        HPP_SETUP: begin
          if (phase_end && style_q == HPP_STYLE_DUAL) begin
            dev_rnw_wr_n_o <= ~write_q;
            dev_oe_rd_n_o  <= write_q;
          end
        end
        HPP_STROBE: begin
          if (phase_end) begin
            dev_cs_n_o <= 1'b1;
            if (style_q == HPP_STYLE_DUAL) begin
              dev_rnw_wr_n_o <= 1'b1;
              dev_oe_rd_n_o  <= 1'b1;
            end
          end
        end
        HPP_HOLD: begin
          if (phase_end) begin
            dev_data_oe_n_o <= 1'b1;
            dev_rnw_wr_n_o  <= 1'b1;
            dev_oe_rd_n_o   <= (style_q == HPP_STYLE_DUAL);
          end
        end
        default: begin
          dev_cs_n_o      <= 1'b1;
          dev_data_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // read data taken at the end of the strobe phase, done on return
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_o <= HPP_DATA_RST;
      done_o  <= 1'b0;
    end else begin
      done_o <= (state_q == HPP_HOLD) && phase_end;
      if (state_q == HPP_STROBE && phase_end && !write_q) begin
        rdata_o <= data_s;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_cs_ends_access: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_q == HPP_HOLD) |-> dev_cs_n_o)
    else $error("chip select low in hold phase");
  a_no_drive_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (dev_cs_n_o && state_q == HPP_IDLE && $past(state_q) == HPP_IDLE)
      |-> dev_data_oe_n_o)
    else $error("data driven while idle");
  a_read_no_drive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!dev_cs_n_o && !write_q && state_q != HPP_IDLE) |-> dev_data_oe_n_o)
    else $error("host drives data on read");
  a_single_oe_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (style_q == HPP_STYLE_SINGLE && state_q != HPP_IDLE)
      |-> !dev_oe_rd_n_o)
    else $error("output enable not grounded");
  a_single_rnw: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!dev_cs_n_o && style_q == HPP_STYLE_SINGLE && state_q != HPP_IDLE)
      |-> dev_rnw_wr_n_o == !write_q)
    else $error("read-not-write wrong");
  a_dual_strobes: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (dev_cs_n_o) |-> (style_q == HPP_STYLE_SINGLE ||
      (dev_rnw_wr_n_o && dev_oe_rd_n_o)) || state_q == HPP_IDLE)
    else $error("strobe low without chip select");
  a_dual_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_q == HPP_STROBE && style_q == HPP_STYLE_DUAL && !write_q)
      |-> !dev_oe_rd_n_o && dev_rnw_wr_n_o)
    else $error("read strobe missing");
  // the pending flag trails the pin by the two synchroniser stages
  a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (!$past(reset_i) && !$past(reset_i, 2))
      |-> irq_pending_o == !$past(dev_irq_n_i, 2))
    else $error("interrupt level wrong");
  a_style_held: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state_q != HPP_IDLE && $past(state_q) != HPP_IDLE)
      |-> $stable(style_q))
    else $error("style changed mid access");
  a_done_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (req_ready_o && req_i) |-> ##[8:14] done_o)
    else $error("access did not finish");

  c_single_wr: cover property (@(posedge sys_clk_i)
    done_o && write_q && style_q == HPP_STYLE_SINGLE);
  c_single_rd: cover property (@(posedge sys_clk_i)
    done_o && !write_q && style_q == HPP_STYLE_SINGLE);
  c_dual_wr: cover property (@(posedge sys_clk_i)
    done_o && write_q && style_q == HPP_STYLE_DUAL);
  c_dual_rd: cover property (@(posedge sys_clk_i)
    done_o && !write_q && style_q == HPP_STYLE_DUAL);
endmodule : hpp_host

// ---- testbench/hpp_dev_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// device model: location space, data bus and interrupt line
// ----------------------------------------------------------------------
module hpp_dev_model
  import hpp_pkg::*;
(
  // configuration
  input  wire logic              style_i,
  input  wire logic              irq_set_i,
  // pins
  input  wire logic [HPP_AW-1:0] addr_i,
  input  wire logic [HPP_DW-1:0] host_data_i,
  input  wire logic              host_oe_n_i,
  input  wire logic              cs_n_i,
  input  wire logic              rnw_wr_n_i,
  input  wire logic              oe_rd_n_i,
  output logic      [HPP_DW-1:0] bus_o,
  output logic                   irq_n_o
);
  logic [HPP_DW-1:0] mem [2**HPP_AW];
  logic [HPP_DW-1:0] last_q;
  logic              wr_act;
  logic              rd_act;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // access decode; nothing happens while chip select is high
  assign wr_act = !cs_n_i && !rnw_wr_n_i;
  assign rd_act = !cs_n_i && !oe_rd_n_i
                  && (style_i || rnw_wr_n_i);
  // a write lands when its strobe or chip select ends it
  always @(negedge wr_act) mem[addr_i] = host_data_i;
  // bus level; an undriven bus shows the inverse of its last value
  always @* begin
    if (!host_oe_n_i) last_q = host_data_i;
    else if (rd_act) last_q = mem[addr_i];
  end
  always @* begin
    if (!host_oe_n_i) bus_o = host_data_i;
    else if (rd_act) bus_o = mem[addr_i];
    else bus_o = ~last_q;
  end
  // open-drain request, pulled up when released
  assign irq_n_o = irq_set_i ? 1'b0 : 1'b1;
endmodule : hpp_dev_model

// ---- testbench/test_hpp_host.sv ----
`timescale 1ns/1ps
module test_hpp_host;
  import hpp_pkg::*;
  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        style, req, req_write, irq_set;
  logic [10:0] req_addr;
  logic [7:0]  req_wdata, rdata, dout, bus;
  logic        ready, done, irq_pend, doe_n, cs_n, rnw, oe, irq_n;
  logic [10:0] daddr;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  hpp_host hpp_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .style_i(style), .req_i(req), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .req_ready_o(ready),
    .done_o(done), .rdata_o(rdata), .irq_pending_o(irq_pend),
    .dev_addr_o(daddr), .dev_data_i(bus), .dev_data_o(dout),
    .dev_data_oe_n_o(doe_n), .dev_cs_n_o(cs_n), .dev_rnw_wr_n_o(rnw),
    .dev_oe_rd_n_o(oe), .dev_irq_n_i(irq_n));
  hpp_dev_model hpp_dev_model_i (.style_i(style), .irq_set_i(irq_set),
    .addr_i(daddr), .host_data_i(dout), .host_oe_n_i(doe_n),
    .cs_n_i(cs_n), .rnw_wr_n_i(rnw), .oe_rd_n_i(oe), .bus_o(bus),
    .irq_n_o(irq_n));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("errors %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  // one access; pins sampled mid strobe and after the end
  task automatic access(input logic st, input logic wr,
                        input logic [10:0] a, input logic [7:0] d);
    int n;
    logic [2:0] mid;
    logic busy;
    @(negedge sys_clk_i);
    check(ready, 1'b1);
    style = st; req = 1'b1; req_write = wr; req_addr = a; req_wdata = d;
    @(negedge sys_clk_i);
    req = 1'b0;
    n = 1;
    mid = 3'h7;
    busy = 1'b1;
    while (done !== 1'b1 && n < 20) begin
      @(negedge sys_clk_i);
      n++;
      if (n == 6) begin
        mid = {cs_n, rnw, oe};
        busy = ready;
      end
    end
    check(done, 1'b1);
    check(mid[2], 1'b0);
    check(busy, 1'b0);
    if (!st) check(oe, 1'b0);
    if (!st) check(mid[1:0], {!wr, 1'b0});
    else check(mid[1:0], {!wr, wr});
    check({cs_n, doe_n}, 2'h3);
  endtask : access
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_single();
    access(1'b0, 1'b1, 11'h7ff, 8'ha5);
    access(1'b0, 1'b1, 11'h000, 8'h5a);
    access(1'b0, 1'b0, 11'h7ff, 8'h00);
    check(rdata, 8'ha5);
    access(1'b0, 1'b0, 11'h000, 8'h00);
    check(rdata, 8'h5a);
  endtask : t_single
  task automatic t_dual();
    access(1'b1, 1'b1, 11'h2aa, 8'h3c);
    access(1'b1, 1'b1, 11'h555, 8'hc3);
    access(1'b1, 1'b0, 11'h2aa, 8'h00);
    check(rdata, 8'h3c);
    access(1'b1, 1'b0, 11'h555, 8'h00);
    check(rdata, 8'hc3);
  endtask : t_dual
  task automatic t_mixed();
    access(1'b0, 1'b1, 11'h123, 8'h96);
    access(1'b1, 1'b0, 11'h123, 8'h00);
    check(rdata, 8'h96);
    access(1'b1, 1'b1, 11'h321, 8'h69);
    access(1'b0, 1'b0, 11'h321, 8'h00);
    check(rdata, 8'h69);
  endtask : t_mixed
  task automatic t_irq();
    irq_set = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check(irq_pend, 1'b1);
    irq_set = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    check(irq_pend, 1'b0);
  endtask : t_irq
  // ----------------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {style, req, req_write, irq_set} = 4'h0;
    req_addr = 11'h000;
    req_wdata = 8'h00;
    repeat (20) @(negedge sys_clk_i);
    reset_i = 1'b0;
    check({cs_n, rnw, oe, doe_n}, 4'hf);
    t_single();
    t_dual();
    t_mixed();
    t_irq();
    results();
  end
endmodule : test_hpp_host
